// ---- rtl/gp_timer_pkg.sv ----
// Package with register map, field positions and constants for the general timer
package gp_timer_pkg;

    // ------------------------------------------------------------------
    // Register map (byte offsets of 16-bit registers, even addresses only)
    // ------------------------------------------------------------------
    localparam logic [3:0] COUNT_REG_ADDR   = 4'h0;
    localparam logic [3:0] PERIOD_REG_ADDR  = 4'h2;
    localparam logic [3:0] CONTROL_REG_ADDR = 4'h4;
    localparam logic [3:0] IRQ_REG_ADDR     = 4'h6;
    localparam logic [3:0] OSC_REG_ADDR     = 4'h8;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTL_TIMER_ON_BIT    = 15;
    localparam int CTL_STOP_IDLE_BIT   = 13;
    localparam int CTL_GATE_BIT        = 6;
    localparam int CTL_PRESCALE_HI_BIT = 5;
    localparam int CTL_PRESCALE_LO_BIT = 4;
    localparam int CTL_SYNC_BIT        = 2;
    localparam int CTL_SOURCE_BIT      = 1;
    localparam int IRQ_FLAG_BIT        = 0;
    localparam int IRQ_ENABLE_BIT      = 1;
    localparam int OSC_LP_ENABLE_BIT   = 1;

    // ------------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------------
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    localparam logic [15:0] PERIOD_RESET  = 16'hFFFF;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] CONTROL_MASK  = 16'hA076;
    localparam logic [15:0] OSC_MASK      = 16'h0002;

    // ------------------------------------------------------------------
    // Prescaler terminal counts (divide minus one)
    // ------------------------------------------------------------------
    localparam logic [7:0] PRESCALE_DIV1_TC   = 8'h00;
    localparam logic [7:0] PRESCALE_DIV8_TC   = 8'h07;
    localparam logic [7:0] PRESCALE_DIV64_TC  = 8'h3F;
    localparam logic [7:0] PRESCALE_DIV256_TC = 8'hFF;

    typedef struct packed {
        logic       timer_on;
        logic       stop_in_idle;
        logic       gate_accumulate_enable;
        logic [1:0] prescale_select;
        logic       external_sync_select;
        logic       clock_source_select;
    } timer_control_t;

    typedef enum logic [2:0] {
        MODE_OFF  = 3'b001,
        MODE_RUN  = 3'b010,
        MODE_HALT = 3'b100
    } run_state_t;

endpackage

// ---- rtl/edge_sync.sv ----
// Two-stage synchroniser with rising and falling edge detect
`timescale 1ns/1ps
module edge_sync
(
    input  wire logic core_clk_i,
    input  wire logic reset_i,
    input  wire logic async_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // ------------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end
        else
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign level_o = sync_q;
    assign rise_o  = sync_q & ~last_q;
    assign fall_o  = ~sync_q & last_q;
endmodule // edge_sync

// ---- rtl/prescaler.sv ----
// Prescale divider producing one tick per selected number of input ticks
`timescale 1ns/1ps
module prescaler
    import gp_timer_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    input  wire logic       enable_i,
    input  wire logic       clear_i,
    input  wire logic       tick_i,
    input  wire logic [1:0] select_i,
    output logic            tick_o
);
    logic [7:0] count_q;
    logic [7:0] terminal;

    always_comb
    begin
        case (select_i)
            2'b00:   terminal = PRESCALE_DIV1_TC;
            2'b01:   terminal = PRESCALE_DIV8_TC;
            2'b10:   terminal = PRESCALE_DIV64_TC;
            default: terminal = PRESCALE_DIV256_TC;
        endcase
    end

    assign tick_o = enable_i & tick_i & (count_q == terminal);

    // ------------------------------------------------------------------
    // Divider counter
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            count_q <= 8'h00;
        end
        else if (!enable_i)
        begin
            count_q <= count_q;
        end
        else if (clear_i)
        begin
            count_q <= 8'h00;
        end
        else if (tick_i)
        begin
            count_q <= (count_q == terminal) ? 8'h00 : 8'(count_q + 8'h01);
        end
    end
endmodule // prescaler

// ---- rtl/gp_timer.sv ----
// General 16-bit timer/counter with gated and real-time-clock modes
//
// Function
// - Internal mode counts cycles, wraps on period
// - Idle stops timer when stop bit set
// - Sync counter counts synchronised external edges
// - Async counter counts edges, halts idle only when stop bit set
// - Gated mode counts cycles while gate high
// - Prescale divides by 1, 8, 64, 256
// - Count or control write clears prescaler while timer on
// - Prescaler frozen while timer off
// - Control write leaves count unchanged
// - Sleep counting only async external source
// - Period match sets flag, requests interrupt
// - Gate falling edge sets flag
// - External low-power oscillator edges counted
// - Oscillator enable blocks normal modes, enables wake on match
// - Clock keeps running through sleep
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module gp_timer
    import gp_timer_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        write_i,
    input  wire logic        read_i,
    output logic      [15:0] rdata_o,
    input  wire logic        instr_tick_i,
    input  wire logic        external_clock_gate_pin_i,
    input  wire logic        lp_osc_clk_i,
    input  wire logic        cpu_idle_i,
    input  wire logic        cpu_sleep_i,
    output logic             irq_o,
    output logic             wake_o,
    output logic             match_o
);
    import gp_timer_pkg::*;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    timer_control_t ctl_q;
    logic [15:0]    count_q;
    logic [15:0]    period_register_q;
    logic           timer_irq_flag_q;
    logic           timer_irq_enable_q;
    logic           low_power_osc_enable_q;
    logic [15:0]    rdata_q;
    logic           wake_q;
    logic           match_q;
    run_state_t     state_q;
    run_state_t     state_d;

    logic ext_level;
    logic ext_rise;
    logic ext_fall;
    logic lp_rise;
    logic ext_async_q;
    logic ext_async_rise;
    logic lp_last_q;
    logic raw_tick;
    logic pre_tick;
    logic count_en;
    logic match;
    logic gate_fall_event;
    logic wr_count;
    logic wr_control;
    logic wr_irq;
    logic prescale_clear;

    assign wr_count   = write_i & (addr_i == COUNT_REG_ADDR);
    assign wr_control = write_i & (addr_i == CONTROL_REG_ADDR);
    assign wr_irq     = write_i & (addr_i == IRQ_REG_ADDR);

    // ------------------------------------------------------------------
    // External input conditioning
    // ------------------------------------------------------------------
    edge_sync i_edge_sync
    (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .async_i    (external_clock_gate_pin_i),
        .level_o    (ext_level),
        .rise_o     (ext_rise),
        .fall_o     (ext_fall)
    );

    // Unsynchronised path: single sample, no phase alignment
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ext_async_q <= 1'b0;
            lp_last_q   <= 1'b0;
        end
        else
        begin
            ext_async_q <= external_clock_gate_pin_i;
            lp_last_q   <= lp_osc_clk_i;
        end
    end

    assign ext_async_rise = external_clock_gate_pin_i & ~ext_async_q;
    assign lp_rise        = lp_osc_clk_i & ~lp_last_q;

    // ------------------------------------------------------------------
    // Run state
    // ------------------------------------------------------------------
    always_comb
    begin
        case (state_q)
            MODE_OFF:  state_d = ctl_q.timer_on ? MODE_RUN : MODE_OFF;
            MODE_RUN,
            MODE_HALT:
            begin
                if (!ctl_q.timer_on)
                    state_d = MODE_OFF;
                else if (cpu_sleep_i && !(ctl_q.clock_source_select
                                          && !ctl_q.external_sync_select))
                    state_d = MODE_HALT;
                else if (cpu_idle_i && ctl_q.stop_in_idle)
                    state_d = MODE_HALT;
                else
                    state_d = MODE_RUN;
            end
            default:   state_d = MODE_OFF;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_q <= MODE_OFF;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // Tick source selection
    // ------------------------------------------------------------------
    always_comb
    begin
        raw_tick = 1'b0;
        if (low_power_osc_enable_q)
        begin
            raw_tick = ctl_q.clock_source_select & lp_rise;
        end
        else if (!ctl_q.clock_source_select)
        begin
            if (ctl_q.gate_accumulate_enable)
                raw_tick = instr_tick_i & ext_level;
            else
                raw_tick = instr_tick_i;
        end
        else if (ctl_q.external_sync_select)
        begin
            raw_tick = ext_rise;
        end
        else
        begin
            raw_tick = ext_async_rise;
        end
    end

    // Sleep and idle gate the tick, not the prescaler, to keep it coherent
    assign count_en = (state_q == MODE_RUN);

    assign prescale_clear = wr_count | wr_control;

    prescaler i_prescaler
    (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .enable_i   (ctl_q.timer_on),
        .clear_i    (prescale_clear),
        .tick_i     (raw_tick & count_en),
        .select_i   (ctl_q.prescale_select),
        .tick_o     (pre_tick)
    );

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    assign match = pre_tick & (count_q == period_register_q);

    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            count_q <= COUNT_RESET;
        end
        else if (wr_count)
        begin
            count_q <= wdata_i;
        end
        // wrap to zero on period match
        else if (match)
        begin
            count_q <= COUNT_RESET;
        end
        // Plain increment; wrap handled above
        else if (pre_tick)
        begin
            count_q <= 16'(count_q + 16'h0001);
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ctl_q                  <= timer_control_t'(7'h00);
            period_register_q      <= PERIOD_RESET;
            timer_irq_enable_q     <= 1'b0;
            low_power_osc_enable_q <= 1'b0;
        end
        else if (write_i)
        begin
            case (addr_i)
                PERIOD_REG_ADDR:  period_register_q <= wdata_i;
                CONTROL_REG_ADDR:
                begin
                    ctl_q.timer_on               <= wdata_i[CTL_TIMER_ON_BIT];
                    ctl_q.stop_in_idle           <= wdata_i[CTL_STOP_IDLE_BIT];
                    ctl_q.gate_accumulate_enable <= wdata_i[CTL_GATE_BIT];
                    ctl_q.prescale_select        <=
                        wdata_i[CTL_PRESCALE_HI_BIT:CTL_PRESCALE_LO_BIT];
                    ctl_q.external_sync_select   <= wdata_i[CTL_SYNC_BIT];
                    ctl_q.clock_source_select    <= wdata_i[CTL_SOURCE_BIT];
                end
                IRQ_REG_ADDR:     timer_irq_enable_q <= wdata_i[IRQ_ENABLE_BIT];
                OSC_REG_ADDR:     low_power_osc_enable_q <= wdata_i[OSC_LP_ENABLE_BIT];
                default:          ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Interrupt flag and events
    // ------------------------------------------------------------------
    // gate falling edge ends accumulation
    assign gate_fall_event = ctl_q.timer_on & ctl_q.gate_accumulate_enable
                           & ~ctl_q.clock_source_select & ext_fall;

    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            timer_irq_flag_q <= 1'b0;
        end
        // match sets flag, set beats clear
        else if (match || gate_fall_event)
        begin
            timer_irq_flag_q <= 1'b1;
        end
        else if (wr_irq)
        begin
            timer_irq_flag_q <= wdata_i[IRQ_FLAG_BIT];
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            wake_q  <= 1'b0;
            match_q <= 1'b0;
        end
        else
        begin
            wake_q  <= low_power_osc_enable_q & match;
            match_q <= match;
        end
    end

    assign irq_o   = timer_irq_flag_q & timer_irq_enable_q;
    assign wake_o  = wake_q;
    assign match_o = match_q;

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rdata_q <= 16'h0000;
        end
        else if (read_i)
        begin
            case (addr_i)
                COUNT_REG_ADDR:   rdata_q <= count_q;
                PERIOD_REG_ADDR:  rdata_q <= period_register_q;
                CONTROL_REG_ADDR:
                begin
                    rdata_q <= 16'h0000;
                    rdata_q[CTL_TIMER_ON_BIT]  <= ctl_q.timer_on;
                    rdata_q[CTL_STOP_IDLE_BIT] <= ctl_q.stop_in_idle;
                    rdata_q[CTL_GATE_BIT]      <= ctl_q.gate_accumulate_enable;
                    rdata_q[CTL_PRESCALE_HI_BIT:CTL_PRESCALE_LO_BIT]
                                               <= ctl_q.prescale_select;
                    rdata_q[CTL_SYNC_BIT]      <= ctl_q.external_sync_select;
                    rdata_q[CTL_SOURCE_BIT]    <= ctl_q.clock_source_select;
                end
                IRQ_REG_ADDR:
                    rdata_q <= {14'h0000, timer_irq_enable_q, timer_irq_flag_q};
                OSC_REG_ADDR:
                    rdata_q <= {14'h0000, low_power_osc_enable_q, 1'b0};
                default:          rdata_q <= 16'h0000;
            endcase
        end
        // Bus reads zero between reads
        else
        begin
            rdata_q <= 16'h0000;
        end
    end

    assign rdata_o = rdata_q;
endmodule // gp_timer

// ---- bench/gp_timer_sva.sv ----
// Checker for bus reads, match, interrupt and wake outputs of the timer
`timescale 1ns/1ps
module gp_timer_sva
    import gp_timer_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        write_i,
    input  wire logic        read_i,
    input  wire logic [15:0] rdata_o,
    input  wire logic        instr_tick_i,
    input  wire logic        external_clock_gate_pin_i,
    input  wire logic        lp_osc_clk_i,
    input  wire logic        cpu_idle_i,
    input  wire logic        cpu_sleep_i,
    input  wire logic        irq_o,
    input  wire logic        wake_o,
    input  wire logic        match_o
);
    // ------------------------------------------------------------------
    // Register shadows built from bus writes
    // ------------------------------------------------------------------
    logic [15:0] per_q;
    logic [15:0] ctl_q;
    logic        en_q;
    logic        osc_q;
    logic        wr_irq;
    logic        mapped;
    assign wr_irq = write_i && (addr_i == IRQ_REG_ADDR);
    assign mapped = (addr_i <= 4'h8) && !addr_i[0];
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            per_q <= PERIOD_RESET;
            ctl_q <= CONTROL_RESET;
            en_q  <= 1'b0;
            osc_q <= 1'b0;
        end
        else if (write_i)
        begin
            if (addr_i == PERIOD_REG_ADDR)
                per_q <= wdata_i;
            if (addr_i == CONTROL_REG_ADDR)
                ctl_q <= wdata_i;
            if (addr_i == IRQ_REG_ADDR)
                en_q <= wdata_i[IRQ_ENABLE_BIT];
            if (addr_i == OSC_REG_ADDR)
                osc_q <= wdata_i[OSC_LP_ENABLE_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    sequence s_read(logic [3:0] a);
        read_i && (addr_i == a);
    endsequence

    a_period_read: assert property (s_read(PERIOD_REG_ADDR) |=> rdata_o == per_q)
        else $error("period readback differs");
    a_control_read: assert property (s_read(CONTROL_REG_ADDR) |=> rdata_o == (ctl_q & CONTROL_MASK))
        else $error("control readback differs");
    a_osc_read: assert property (s_read(OSC_REG_ADDR) |=> rdata_o == {14'h0000, osc_q, 1'b0})
        else $error("osc readback differs");
    a_unmapped_zero: assert property (read_i && !mapped |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    a_irq_gated: assert property (irq_o |-> en_q)
        else $error("irq without enable");
    a_match_flag: assert property (match_o && en_q |-> irq_o)
        else $error("match did not raise irq");
    a_flag_sticky: assert property (irq_o && !wr_irq |=> irq_o)
        else $error("irq dropped without software");
    a_wake_on_match: assert property (wake_o |-> match_o && $past(osc_q))
        else $error("wake without match");
    a_off_quiet: assert property (!ctl_q[CTL_TIMER_ON_BIT] [*6] |-> !match_o && !wake_o)
        else $error("match while timer off");
    a_match_single: assert property (match_o && (per_q != 16'h0000) |=> !match_o)
        else $error("match longer than a cycle");
endmodule // gp_timer_sva

bind gp_timer gp_timer_sva i_gp_timer_sva (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i),
    .rdata_o(rdata_o), .instr_tick_i(instr_tick_i),
    .external_clock_gate_pin_i(external_clock_gate_pin_i), .lp_osc_clk_i(lp_osc_clk_i),
    .cpu_idle_i(cpu_idle_i), .cpu_sleep_i(cpu_sleep_i), .irq_o(irq_o), .wake_o(wake_o),
    .match_o(match_o));

// ---- bench/ext_source_model.sv ----
// External clock, gate and low-power oscillator stand-in
`timescale 1ns/1ps
module ext_source_model
(
    input  wire logic       core_clk_i,
    input  wire logic       gate_i,
    input  wire logic       lp_sel_i,
    input  wire logic [7:0] edges_i,
    input  wire logic       go_i,
    output logic            ext_pin_o,
    output logic            lp_clk_o,
    output logic            busy_o
);
    logic [7:0] n_q = 8'h00;
    logic [2:0] ph_q = 3'h0;
    logic       hi;
    // Clocks stand still low between bursts
    assign busy_o = (n_q != 8'h00);
    assign hi     = busy_o && (ph_q < 3'h3);
    // oscillator edges on their own line
    assign lp_clk_o  = lp_sel_i && hi;
    assign ext_pin_o = gate_i || (!lp_sel_i && hi);
    always_ff @(posedge core_clk_i)
    begin
        if (go_i)
        begin
            n_q  <= edges_i;
            ph_q <= 3'h0;
        end
        else if (busy_o)
        begin
            ph_q <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
            if (ph_q == 3'h5)
                n_q <= n_q - 8'h01;
        end
    end
endmodule // ext_source_model

// ---- bench/general_timer_with_rtc_mode_bench.sv ----
// Self-checking bench for the general timer
`timescale 1ns/1ps
module general_timer_with_rtc_mode_bench;
    import gp_timer_pkg::*;
    logic core_clk_i = 0, reset_i = 1, write_i = 0, read_i = 0, instr_tick_i = 0;
    logic cpu_idle_i = 0, cpu_sleep_i = 0, gate = 0, lp_sel = 0, go = 0;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000, rdata_o, v;
    logic [7:0] n_edges = 8'h00;
    logic irq_o, wake_o, match_o, ext_pin, lp_clk, busy;
    int fail_count = 0, checks = 0, wake_n = 0, k, p, n;
    always #4 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) if (wake_o === 1'b1) wake_n <= wake_n + 1;
    gp_timer i_gp_timer (.core_clk_i(core_clk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
        .instr_tick_i(instr_tick_i), .external_clock_gate_pin_i(ext_pin),
        .lp_osc_clk_i(lp_clk), .cpu_idle_i(cpu_idle_i), .cpu_sleep_i(cpu_sleep_i),
        .irq_o(irq_o), .wake_o(wake_o), .match_o(match_o));
    ext_source_model i_ext_source_model (.core_clk_i(core_clk_i), .gate_i(gate),
        .lp_sel_i(lp_sel), .edges_i(n_edges), .go_i(go), .ext_pin_o(ext_pin),
        .lp_clk_o(lp_clk), .busy_o(busy));

    // ------------------------------------------------------------------
    // Tasks and expectation functions
    // ------------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        write_i <= 1'b1;
        @(posedge core_clk_i);
        write_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge core_clk_i);
        addr_i <= a;
        read_i <= 1'b1;
        @(posedge core_clk_i);
        read_i <= 1'b0;
        @(posedge core_clk_i);
        d = rdata_o;
    endtask
    task automatic expect_count(input logic [15:0] exp);
        repeat (6) @(posedge core_clk_i);
        rd(COUNT_REG_ADDR, v);
        chk("count", exp, v);
    endtask
    task automatic tick(input int t);
        repeat (t) @(posedge core_clk_i) instr_tick_i <= 1'b1;
        @(posedge core_clk_i) instr_tick_i <= 1'b0;
    endtask
    task automatic edges(input logic sel, input int e);
        @(posedge core_clk_i);
        lp_sel  <= sel;
        n_edges <= 8'(e);
        go      <= 1'b1;
        @(posedge core_clk_i) go <= 1'b0;
        @(posedge core_clk_i);
        for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge core_clk_i);
        if (busy !== 1'b0)
        begin
            fail_count++;
            complete_run();
        end
    endtask
    function automatic logic [15:0] ctl(input logic on, input logic idl, input logic gt,
        input logic [1:0] ps, input logic sy, input logic src);
        ctl = {on, 1'b0, idl, 6'h00, gt, ps, 1'b0, sy, src, 1'b0};
    endfunction
    function automatic int pdiv(input logic [1:0] ps);
        pdiv = (ps == 2'h0) ? 1 : (ps == 2'h1) ? 8 : (ps == 2'h2) ? 64 : 256;
    endfunction

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        k = $urandom(24924);
        repeat (6) @(posedge core_clk_i);
        reset_i <= 1'b0;
        rd(COUNT_REG_ADDR, v);
        chk("count reset", COUNT_RESET, v);
        rd(PERIOD_REG_ADDR, v);
        chk("period reset", PERIOD_RESET, v);
        rd(CONTROL_REG_ADDR, v);
        chk("control reset", CONTROL_RESET, v);
        rd(4'hF, v);
        chk("unmapped", 16'h0000, v);
        for (int ps = 0; ps < 4; ps++)
        begin
            wr(CONTROL_REG_ADDR, ctl(1, 0, 0, 2'(ps), 0, 0));
            wr(COUNT_REG_ADDR, 16'h0000);
            k = $urandom_range(600, 1);
            tick(k);
            expect_count(16'(k / pdiv(2'(ps))));
        end
        p = $urandom_range(20, 3);
        wr(CONTROL_REG_ADDR, ctl(1, 0, 0, 2'h0, 0, 0));
        wr(PERIOD_REG_ADDR, 16'(p));
        wr(IRQ_REG_ADDR, 16'h0002);
        wr(COUNT_REG_ADDR, 16'h0000);
        k = p + 1 + $urandom_range(p, 0);
        tick(k);
        expect_count(16'(k - p - 1));
        chk("irq", 16'h0001, {15'h0000, irq_o});
        wr(IRQ_REG_ADDR, 16'h0002);
        #1 chk("irq cleared", 16'h0000, {15'h0000, irq_o});
        wr(PERIOD_REG_ADDR, 16'hFFFF);
        wr(CONTROL_REG_ADDR, ctl(1, 1, 0, 2'h0, 0, 0));
        wr(COUNT_REG_ADDR, 16'h0000);
        cpu_idle_i <= 1'b1;
        tick(20);
        expect_count(16'h0000);
        cpu_idle_i <= 1'b0;
        tick(5);
        expect_count(16'h0005);
        wr(CONTROL_REG_ADDR, ctl(1, 0, 0, 2'h0, 0, 0));
        expect_count(16'h0005);
        cpu_idle_i <= 1'b1;
        tick(7);
        expect_count(16'h000C);
        cpu_idle_i <= 1'b0;
        wr(CONTROL_REG_ADDR, ctl(0, 0, 0, 2'h0, 0, 0));
        tick(9);
        expect_count(16'h000C);
        wr(IRQ_REG_ADDR, 16'h0000);
        wr(CONTROL_REG_ADDR, ctl(1, 0, 1, 2'h0, 0, 0));
        wr(COUNT_REG_ADDR, 16'h0000);
        tick(10);
        gate <= 1'b1;
        repeat (5) @(posedge core_clk_i);
        k = $urandom_range(50, 1);
        tick(k);
        gate <= 1'b0;
        repeat (5) @(posedge core_clk_i);
        tick(10);
        expect_count(16'(k));
        rd(IRQ_REG_ADDR, v);
        chk("gate flag", 16'h0001, v);
        wr(IRQ_REG_ADDR, 16'h0000);
        wr(CONTROL_REG_ADDR, ctl(1, 0, 0, 2'h0, 1, 1));
        wr(COUNT_REG_ADDR, 16'h0000);
        n = $urandom_range(40, 1);
        edges(0, n);
        expect_count(16'(n));
        cpu_sleep_i <= 1'b1;
        edges(0, 5);
        expect_count(16'(n));
        // sync kept off for the asynchronous and clock runs
        wr(CONTROL_REG_ADDR, ctl(1, 0, 0, 2'h0, 0, 1));
        edges(0, 4);
        expect_count(16'(n + 4));
        cpu_sleep_i <= 1'b0;
        wr(CONTROL_REG_ADDR, ctl(1, 1, 0, 2'h0, 0, 1));
        cpu_idle_i <= 1'b1;
        edges(0, 3);
        expect_count(16'(n + 4));
        cpu_idle_i <= 1'b0;
        wr(OSC_REG_ADDR, 16'h0002);
        wr(CONTROL_REG_ADDR, ctl(1, 0, 0, 2'h0, 0, 1));
        wr(PERIOD_REG_ADDR, 16'h0003);
        wr(COUNT_REG_ADDR, 16'h0000);
        cpu_sleep_i <= 1'b1;
        edges(1, 6);
        expect_count(16'h0002);
        chk("wake count", 16'h0001, 16'(wake_n));
        cpu_sleep_i <= 1'b0;
        wr(CONTROL_REG_ADDR, ctl(1, 0, 0, 2'h0, 0, 0));
        wr(COUNT_REG_ADDR, 16'h0000);
        tick(10);
        expect_count(16'h0000);
        complete_run();
    end
endmodule // general_timer_with_rtc_mode_bench
